// ---- swpc_pkg.sv ----
// Package with constants and types for the sleep and wake power controller.
package swpc_pkg;

  // Register offsets on the plain register port.
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_WAKE_EN = 4'h4;
  localparam logic [3:0] OFS_SLEEP_CMD = 4'h8;
  localparam logic [3:0] OFS_STATUS = 4'hC;

  // Control register fields.
  localparam int CTRL_RESTORE_LSB = 0;   // Two bits: stay off, power on, last state.
  localparam int CTRL_DUAL_LED_BIT = 2;  // One when the front-panel LED has two colours.
  localparam int CTRL_PCI_EVENT_BIT = 3; // Master enable for PCI event wake.
  localparam int CTRL_BTN_SLEEP_LSB = 4; // Three-bit sleep code used by a short button press.
  localparam logic [6:0] CTRL_RESET = 7'h32;

  // After-AC-loss restore settings.
  localparam logic [1:0] RESTORE_OFF = 2'h0;
  localparam logic [1:0] RESTORE_ON = 2'h1;
  localparam logic [1:0] RESTORE_LAST = 2'h2;

  // Sleep codes written by software and used by the button.
  localparam logic [2:0] CODE_S1 = 3'h1;
  localparam logic [2:0] CODE_S3 = 3'h3;
  localparam logic [2:0] CODE_S4 = 3'h4;
  localparam logic [2:0] CODE_S5 = 3'h5;
  localparam int CMD_GO_BIT = 3;

  // Wake source slots, four sleep-state bits each: S1, S3, S4, S5 from bit 0 up.
  localparam int SRC_USB = 0;
  localparam int SRC_CIR = 1;
  localparam int SRC_PCI_EVENT = 2;
  localparam int SRC_PCIE_WAKE = 3;
  localparam int SRC_LAN = 4;
  localparam int SRC_N = 5;
  localparam logic [19:0] WAKE_EN_RESET = 20'h7F733;
  localparam logic [19:0] WAKE_EN_WMASK = 20'hF0FF3;
  localparam logic [19:0] WAKE_EN_FORCE = 20'h0F000;

  // Status register fields.
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_WAS_ON_BIT = 3;
  localparam int STAT_PS_ON_BIT = 4;
  localparam int STAT_AC_OK_BIT = 5;
  localparam int STAT_SRC_LSB = 8;
  localparam int STAT_BTN_BIT = 13;

  // Timing of the power switch.
  localparam int CLK_HZ = 50_000_000;
  localparam int BTN_LONG_S = 4;
  localparam int BTN_LONG_CYC = BTN_LONG_S * CLK_HZ;

  // Power states; G3 stands for AC power absent.
  typedef enum logic [2:0] {ST_S0, ST_S1, ST_S3, ST_S4, ST_S5, ST_G3} swpc_state_t;

endpackage : swpc_pkg

// ---- swpc_sync.sv ----
// Two-flop synchroniser for asynchronous pins.
`timescale 1ns/100ps
module swpc_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic ref_clk,         // System clock.
  input wire logic nrst,            // Synchronous reset, active low.
  input wire logic clk_en,          // Clock enable.
  input wire logic [W-1:0] d,       // Asynchronous input.
  output logic [W-1:0] q            // Synchronised output.
);

  logic [W-1:0] meta_r;

  // The first flop feeds only the second one, so metastability never reaches logic.
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      meta_r <= INIT;
      q <= INIT;
    end else if (clk_en) begin
      meta_r <= d;
      q <= meta_r;
    end
  end

endmodule : swpc_sync

// ---- swpc_ctrl.sv ----
// Sleep and wake power controller: state tracking, wake gating, supply, fans and LED.
//
// How it works
// - Fans run while the system is in S0.
// - Fans are off when off or in S3, S4 or S5.
// - A valid software soft-off drops main rails, standby logic stays alive.
// - After AC returns, restore on or off according to restore setting.
// - USB activity wakes the system from S1 or S3.
// - Infrared wakes from S1 and S3; from S4 and S5 only when enabled.
// - PCI event line wakes from any sleep state when its enable is on.
// - PCI Express wake line wakes from any sleep state, always enabled.
// - In S3 supply is off; LED amber if dual-colour, dark otherwise.
// - Any enabled wake during S3 returns the system to working state.
// - Short press toggles on, sleep or wake; press past four seconds forces soft-off.
// - Network and PCI event wake from S5 are off after reset.
//
// Our own choices: the strobed register port and the placing of the registers.
`timescale 1ns/100ps
module swpc_ctrl #(
  parameter int FAN_N = 2,
  parameter int BTN_LONG_CYC = swpc_pkg::BTN_LONG_CYC
) (
  input wire logic ref_clk,              // 50 MHz standby clock.
  input wire logic nrst,                 // Synchronous reset, active low.
  input wire logic clk_en,               // Freezes all state while low.
  input wire logic [3:0] reg_addr,       // Register byte address.
  input wire logic [31:0] reg_wdata,     // Register write data.
  input wire logic reg_wr,               // Write strobe.
  input wire logic reg_rd,               // Read strobe.
  output logic [31:0] reg_rdata,         // Read data, valid the cycle after the strobe.
  input wire logic pwr_btn_n,            // Front-panel power switch, low while pressed.
  input wire logic ac_ok,                // High while AC power is present.
  input wire logic usb_act,              // USB bus activity.
  input wire logic cir_act,              // Consumer infrared activity.
  input wire logic pci_event_n,          // PCI power event line, active low.
  input wire logic pcie_wake_n,          // PCI Express wake line, active low.
  input wire logic lan_wake,             // Network wake request.
  output logic ps_on,                    // Main supply on request.
  output logic [FAN_N-1:0] fan_en,       // Fan enables.
  output logic led_green,                // Front-panel LED, working colour.
  output logic led_amber                 // Front-panel LED, suspend colour.
);

  // Pins are synchronised; the inactive value is loaded at reset.
  logic [6:0] pin_raw;
  logic [6:0] pin_s;
  assign pin_raw = {lan_wake, pcie_wake_n, pci_event_n, cir_act, usb_act, ac_ok, pwr_btn_n};

  // The load value must match the idle level of every pin, or AC would look lost right after reset.
  swpc_sync #(
    .W(7),
    .INIT(7'h33)
  ) u_sync (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .clk_en(clk_en),
    .d(pin_raw),
    .q(pin_s)
  );

  wire btn_down = ~pin_s[0];
  wire ac_now = pin_s[1];
  wire [swpc_pkg::SRC_N-1:0] src_act = {pin_s[6], ~pin_s[5], ~pin_s[4], pin_s[3], pin_s[2]};

  // Registers and state.
  swpc_pkg::swpc_state_t state_r, state_nxt;
  logic [6:0] ctrl_r;
  logic [19:0] wake_en_r;
  logic was_on_r, was_on_nxt;
  logic ac_prev_r;
  logic [swpc_pkg::SRC_N-1:0] wake_src_r, wake_src_nxt;
  logic btn_wake_r, btn_wake_nxt;
  logic btn_set;
  logic [31:0] btn_cnt_r;
  logic btn_long_r;
  logic btn_prev_r;
  logic ps_on_r;
  logic [FAN_N-1:0] fan_en_r;
  logic led_green_r, led_amber_r;
  logic [31:0] reg_rdata_r;

  // Register decode.
  wire wr_ctrl = reg_wr && (reg_addr == swpc_pkg::OFS_CTRL);
  wire wr_wake = reg_wr && (reg_addr == swpc_pkg::OFS_WAKE_EN);
  wire wr_cmd = reg_wr && (reg_addr == swpc_pkg::OFS_SLEEP_CMD);
  wire wr_stat = reg_wr && (reg_addr == swpc_pkg::OFS_STATUS);
  wire [1:0] restore_mode = ctrl_r[swpc_pkg::CTRL_RESTORE_LSB +: 2];
  wire dual_led = ctrl_r[swpc_pkg::CTRL_DUAL_LED_BIT];
  wire pci_event_en = ctrl_r[swpc_pkg::CTRL_PCI_EVENT_BIT];
  wire [2:0] btn_sleep_code = ctrl_r[swpc_pkg::CTRL_BTN_SLEEP_LSB +: 3];
  wire [2:0] cmd_code = reg_wdata[2:0];
  wire cmd_go = wr_cmd && reg_wdata[swpc_pkg::CMD_GO_BIT];

  // Effective enables: USB can never wake from S4 or S5, PCI Express wake is always on.
  // per state enables
  wire [19:0] wake_en_eff = (wake_en_r & swpc_pkg::WAKE_EN_WMASK) | swpc_pkg::WAKE_EN_FORCE;

  // Current sleep slot in each source's four enable bits.
  logic [1:0] slot;
  logic sleeping;
  always_comb begin
    slot = 2'h0;
    sleeping = 1'b1;
    unique case (state_r)
      swpc_pkg::ST_S1: slot = 2'h0;
      swpc_pkg::ST_S3: slot = 2'h1;
      swpc_pkg::ST_S4: slot = 2'h2;
      swpc_pkg::ST_S5: slot = 2'h3;
      swpc_pkg::ST_S0, swpc_pkg::ST_G3: sleeping = 1'b0;
    endcase
  end

  // One gate per source: active, enabled for this state, and sleeping.
  logic [swpc_pkg::SRC_N-1:0] src_hit;
  genvar gi;
  generate
    for (gi = 0; gi < swpc_pkg::SRC_N; gi++) begin : g_src
      assign src_hit[gi] = sleeping && src_act[gi] && wake_en_eff[gi*4 + slot];
    end
  endgenerate

  // S5 defaults come from reset value
  wire [swpc_pkg::SRC_N-1:0] src_gated = src_hit &
    ~(pci_event_en ? 5'h00 : (5'h01 << swpc_pkg::SRC_PCI_EVENT));
  wire wake_any = |src_gated;

  // Power switch timing. The counter saturates, so a held switch acts once.
  wire [31:0] btn_limit = 32'(BTN_LONG_CYC);
  wire btn_hit_long = btn_down && !btn_long_r && (btn_cnt_r + 32'h1 >= btn_limit);
  wire btn_short = btn_prev_r && !btn_down && !btn_long_r;

  // AC loss and return edges.
  wire ac_fall = ac_prev_r && !ac_now;
  wire ac_rise = !ac_prev_r && ac_now;

  // Maps a sleep code to a state; anything else is refused.
  function automatic logic code_ok(input logic [2:0] c);
    code_ok = (c == swpc_pkg::CODE_S1) || (c == swpc_pkg::CODE_S3) ||
              (c == swpc_pkg::CODE_S4) || (c == swpc_pkg::CODE_S5);
  endfunction : code_ok

  function automatic swpc_pkg::swpc_state_t code_state(input logic [2:0] c);
    code_state = swpc_pkg::ST_S5;
    if (c == swpc_pkg::CODE_S1) begin
      code_state = swpc_pkg::ST_S1;
    end else if (c == swpc_pkg::CODE_S3) begin
      code_state = swpc_pkg::ST_S3;
    end else if (c == swpc_pkg::CODE_S4) begin
      code_state = swpc_pkg::ST_S4;
    end
  endfunction : code_state

  // State transitions. Priority: AC, long press, short press, wake, software.
  always_comb begin
    state_nxt = state_r;
    was_on_nxt = was_on_r;
    btn_wake_nxt = btn_wake_r;
    btn_set = 1'b0;
    if (ac_fall) begin
      // The last state is kept so that the restore setting can use it.
      was_on_nxt = (state_r != swpc_pkg::ST_S5) && (state_r != swpc_pkg::ST_G3);
      state_nxt = swpc_pkg::ST_G3;
    end else if (state_r == swpc_pkg::ST_G3) begin
      if (ac_rise) begin
        if ((restore_mode == swpc_pkg::RESTORE_ON) ||
            ((restore_mode == swpc_pkg::RESTORE_LAST) && was_on_r)) begin
          state_nxt = swpc_pkg::ST_S0;
        end else begin
          state_nxt = swpc_pkg::ST_S5;
        end
      end
    end else if (btn_hit_long) begin
      state_nxt = swpc_pkg::ST_S5;
    end else if (btn_short) begin
      if (state_r == swpc_pkg::ST_S0) begin
        if (code_ok(btn_sleep_code)) begin
          state_nxt = code_state(btn_sleep_code);
        end
      end else begin
        state_nxt = swpc_pkg::ST_S0;
        btn_wake_nxt = 1'b1;
        btn_set = 1'b1;
      end
    end else if (wake_any) begin
      state_nxt = swpc_pkg::ST_S0;
    end else if (cmd_go && (state_r == swpc_pkg::ST_S0) && code_ok(cmd_code)) begin
      state_nxt = code_state(cmd_code);
    end
    if (wr_stat && reg_wdata[swpc_pkg::STAT_BTN_BIT]) begin
      // Only a button wake taken in this very cycle survives the clear.
      btn_wake_nxt = btn_set;
    end
  end

  // Sticky wake cause; a new wake in the clearing cycle wins over the clear.
  always_comb begin
    wake_src_nxt = wake_src_r;
    if (wr_stat) begin
      wake_src_nxt = wake_src_r & ~reg_wdata[swpc_pkg::STAT_SRC_LSB +: swpc_pkg::SRC_N];
    end
    if (state_nxt == swpc_pkg::ST_S0 && wake_any && !ac_fall && !btn_hit_long && !btn_short) begin
      wake_src_nxt = wake_src_nxt | src_gated;
    end
  end

  // Outputs decoded from the next state so they leave flip-flops in step with it.
  // fans on in S0
  wire fan_nxt = (state_nxt == swpc_pkg::ST_S0);
  // main rails only in S0 and S1
  wire ps_on_nxt = (state_nxt == swpc_pkg::ST_S0) || (state_nxt == swpc_pkg::ST_S1);
  wire amber_nxt = (state_nxt == swpc_pkg::ST_S3) && dual_led;
  wire green_nxt = ps_on_nxt;

  // Read mux; unmapped addresses read zero.
  wire [31:0] status_word = {18'h0, btn_wake_r, wake_src_r, 2'h0, ac_now, ps_on_r, was_on_r,
                             3'(state_r)};
  wire [31:0] rd_mux = (reg_addr == swpc_pkg::OFS_CTRL) ? {25'h0, ctrl_r} :
                       (reg_addr == swpc_pkg::OFS_WAKE_EN) ? {12'h0, wake_en_eff} :
                       (reg_addr == swpc_pkg::OFS_STATUS) ? status_word : 32'h0;

  // Configuration registers.
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      ctrl_r <= swpc_pkg::CTRL_RESET;
      wake_en_r <= swpc_pkg::WAKE_EN_RESET;
    end else if (clk_en) begin
      if (wr_ctrl) begin
        ctrl_r <= reg_wdata[6:0];
      end
      if (wr_wake) begin
        wake_en_r <= reg_wdata[19:0];
      end
    end
  end

  // Power switch press timer.
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      btn_cnt_r <= 32'h0;
      btn_long_r <= 1'b0;
      btn_prev_r <= 1'b0;
    end else if (clk_en) begin
      btn_prev_r <= btn_down;
      if (!btn_down) begin
        btn_cnt_r <= 32'h0;
        btn_long_r <= 1'b0;
      end else if (!btn_long_r) begin
        btn_cnt_r <= btn_cnt_r + 32'h1;
        btn_long_r <= btn_hit_long;
      end
    end
  end

  // State and status. Reset assumes AC present and the system off.
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      state_r <= swpc_pkg::ST_S5;
      was_on_r <= 1'b0;
      ac_prev_r <= 1'b1;
      wake_src_r <= '0;
      btn_wake_r <= 1'b0;
    end else if (clk_en) begin
      state_r <= state_nxt;
      was_on_r <= was_on_nxt;
      ac_prev_r <= ac_now;
      wake_src_r <= wake_src_nxt;
      btn_wake_r <= btn_wake_nxt;
    end
  end

  // Output flops.
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      ps_on_r <= 1'b0;
      fan_en_r <= '0;
      led_green_r <= 1'b0;
      led_amber_r <= 1'b0;
      reg_rdata_r <= 32'h0;
    end else if (clk_en) begin
      ps_on_r <= ps_on_nxt;
      fan_en_r <= {FAN_N{fan_nxt}};
      led_green_r <= green_nxt;
      led_amber_r <= amber_nxt;
      reg_rdata_r <= reg_rd ? rd_mux : 32'h0;
    end
  end

  assign ps_on = ps_on_r;
  assign fan_en = fan_en_r;
  assign led_green = led_green_r;
  assign led_amber = led_amber_r;
  assign reg_rdata = reg_rdata_r;

endmodule : swpc_ctrl

// ---- swpc_ctrl_monitor.sv ----
// Port checker for the sleep and wake power controller.
`timescale 1ns/100ps
module swpc_ctrl_check #(
  parameter int FAN_N = 2
) (
  input wire logic ref_clk, // Clock.
  input wire logic nrst, // Reset, active low.
  input wire logic [3:0] reg_addr, // Register address.
  input wire logic [31:0] reg_wdata, // Write data.
  input wire logic reg_wr, // Write strobe.
  input wire logic reg_rd, // Read strobe.
  input wire logic [31:0] reg_rdata, // Read data.
  input wire logic pwr_btn_n, // Power switch.
  input wire logic ac_ok, // AC present.
  input wire logic pcie_wake_n, // Express wake line.
  input wire logic ps_on, // Supply request.
  input wire logic [FAN_N-1:0] fan_en, // Fan enables.
  input wire logic led_green, // Working LED.
  input wire logic led_amber // Suspend LED.
);
  // All checks share the one standby clock and its reset.
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  // Output relations; pin-driven ones allow the two synchroniser flops plus one state edge.
  a_fans_need_supply: assert property (|fan_en |-> ps_on && led_green)
    else $error("fans run without supply");
  a_fans_together: assert property (fan_en == '0 || &fan_en)
    else $error("fans split");
  a_s3_dark_supply: assert property (led_amber |-> !ps_on && !led_green && fan_en == '0)
    else $error("amber with supply on");
  a_green_tracks: assert property (led_green == ps_on)
    else $error("green LED differs from supply");
  a_soft_off_cmd: assert property (reg_wr && reg_addr == swpc_pkg::OFS_SLEEP_CMD
    && reg_wdata[3:0] == 4'hD && &fan_en && ac_ok && pwr_btn_n |=> !ps_on && fan_en == '0)
    else $error("soft-off did not drop supply");
  // A three-cycle pulse is enough: two synchroniser flops and one state edge later the fans run.
  a_pcie_wakes: assert property ($fell(pcie_wake_n) ##0 (!pcie_wake_n && ac_ok)[*3] |-> ##[1:2] &fan_en)
    else $error("express wake ignored");
  a_no_ac_off: assert property (!ac_ok [*5] |-> !ps_on && fan_en == '0)
    else $error("supply on without AC");
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == '0)
    else $error("read data outside read cycle");

  // Main scenarios seen.
  c_soft_off: cover property ($fell(ps_on));
  c_amber: cover property (led_amber);
  c_wake: cover property ($rose(fan_en[0]) && !$past(ps_on));
endmodule : swpc_ctrl_check

bind swpc_ctrl swpc_ctrl_check #(.FAN_N(FAN_N)) chk (.ref_clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .pwr_btn_n, .ac_ok, .pcie_wake_n, .ps_on, .fan_en, .led_green, .led_amber);

// ---- swpc_far_side.sv ----
// Model of the power switch, AC feed and wake sources around the controller.
`timescale 1ns/100ps
module swpc_far_side (
  input wire logic ref_clk, // Clock.
  output logic [6:0] ev // Active high: sources 0 to 4, switch pressed 5, AC lost 6.
);
  // Everything idle at power-up: lines released, AC present.
  initial begin
    ev = 7'h00;
  end

  // Holds one event for n cycles; changes only just after an edge.
  // any one of the seven event lines, chosen by sel.
  task automatic hold(input int sel, input int n);
    @(posedge ref_clk);
    ev[sel] <= 1'b1;
    repeat (n) @(posedge ref_clk);
    ev[sel] <= 1'b0;
  endtask : hold
endmodule : swpc_far_side

// ---- tb_swpc_ctrl.sv ----
// Self-checking testbench for the sleep and wake power controller.
`timescale 1ns/100ps
module tb_swpc_ctrl;
  localparam int LONG = 20;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic clk_en = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [6:0] ev;
  logic ps_on;
  logic led_green;
  logic led_amber;
  logic [1:0] fan_en;
  int errors = 0;
  int n_tests = 0;

  // 50 MHz clock.
  always #10 ref_clk = ~ref_clk;

  swpc_ctrl #(.FAN_N(2), .BTN_LONG_CYC(LONG)) uut (.ref_clk, .nrst, .clk_en, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .pwr_btn_n(~ev[5]), .ac_ok(~ev[6]), .usb_act(ev[0]), .cir_act(ev[1]),
    .pci_event_n(~ev[2]), .pcie_wake_n(~ev[3]), .lan_wake(ev[4]), .ps_on, .fan_en, .led_green, .led_amber);
  swpc_far_side far (.ref_clk, .ev);

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // Bus cycles: one strobe cycle each, read data sampled mid-way through the following cycle.
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    d = reg_rdata;
  endtask : rd

  // Supply, fans and green LED all follow from the state.
  task automatic expect_st(input swpc_pkg::swpc_state_t st);
    logic [31:0] d;
    logic on;
    on = (st == swpc_pkg::ST_S0 || st == swpc_pkg::ST_S1);
    rd(swpc_pkg::OFS_STATUS, d);
    check("state", {29'h0, st}, {29'h0, d[2:0]});
    check("ps_on", {31'h0, on}, {31'h0, ps_on});
    check("led_green", {31'h0, on}, {31'h0, led_green});
    check("fan_en", (st == swpc_pkg::ST_S0) ? 32'h3 : 32'h0, {30'h0, fan_en});
  endtask : expect_st

  // A short press, then time for the pin to pass the synchroniser.
  task automatic tap();
    far.hold(5, 3);
    repeat (5) @(posedge ref_clk);
  endtask : tap

  task automatic t_regs();
    logic [31:0] d;
    rd(swpc_pkg::OFS_CTRL, d);
    check("ctrl", {25'h0, swpc_pkg::CTRL_RESET}, d);
    rd(swpc_pkg::OFS_WAKE_EN, d);
    check("wake_en", {12'h0, swpc_pkg::WAKE_EN_RESET}, d);
    wr(swpc_pkg::OFS_WAKE_EN, 32'hFFFFFFFF);
    rd(swpc_pkg::OFS_WAKE_EN, d);
    check("wake_en ones", 32'h000FFFF3, d);
    wr(swpc_pkg::OFS_WAKE_EN, 32'h0);
    rd(swpc_pkg::OFS_WAKE_EN, d);
    check("wake_en zero", 32'h0000F000, d);
    wr(4'h2, 32'hFFFFFFFF);
    rd(4'h2, d);
    check("unmapped", 32'h0, d);
    rd(swpc_pkg::OFS_SLEEP_CMD, d);
    check("sleep_cmd", 32'h0, d);
    wr(swpc_pkg::OFS_WAKE_EN, {12'h0, swpc_pkg::WAKE_EN_RESET});
    expect_st(swpc_pkg::ST_S5);
    $display("t_regs done");
  endtask : t_regs

  task automatic t_button();
    tap();
    expect_st(swpc_pkg::ST_S0);
    tap();
    expect_st(swpc_pkg::ST_S3);
    tap();
    expect_st(swpc_pkg::ST_S0);
    far.hold(5, LONG + 6);
    repeat (5) @(posedge ref_clk);
    expect_st(swpc_pkg::ST_S5);
    tap();
    $display("t_button done");
  endtask : t_button

  task automatic t_soft();
    wr(swpc_pkg::OFS_SLEEP_CMD, 32'hA);
    expect_st(swpc_pkg::ST_S0);
    wr(swpc_pkg::OFS_SLEEP_CMD, 32'hD);
    expect_st(swpc_pkg::ST_S5);
    wr(swpc_pkg::OFS_SLEEP_CMD, 32'hB);
    expect_st(swpc_pkg::ST_S5);
    tap();
    $display("t_soft done");
  endtask : t_soft

  // Suspend with each LED kind, woken by USB on one and infrared on the other.
  task automatic t_s3();
    logic [31:0] d;
    for (int dual = 0; dual < 2; dual++) begin
      wr(swpc_pkg::OFS_CTRL, 32'h32 | (dual << 2));
      wr(swpc_pkg::OFS_SLEEP_CMD, 32'hB);
      expect_st(swpc_pkg::ST_S3);
      check("led_amber", dual, {31'h0, led_amber});
      far.hold(dual, 3);
      repeat (5) @(posedge ref_clk);
      expect_st(swpc_pkg::ST_S0);
      rd(swpc_pkg::OFS_STATUS, d);
      check("wake source", 32'h1 << dual, {27'h0, d[12:8]});
      wr(swpc_pkg::OFS_STATUS, 32'h3F00);
      rd(swpc_pkg::OFS_STATUS, d);
      check("source cleared", 32'h0, {26'h0, d[13:8]});
    end
    $display("t_s3 done");
  endtask : t_s3

  task automatic try_wake(input logic [2:0] code, input int src, input logic woke);
    wr(swpc_pkg::OFS_SLEEP_CMD, {28'h0, 1'b1, code});
    far.hold(src, 3);
    repeat (5) @(posedge ref_clk);
    // Look away from the edge so the fan enables are settled.
    @(negedge ref_clk);
    check("woke", {31'h0, woke}, {31'h0, &fan_en});
    if (!woke) begin
      tap();
    end
    expect_st(swpc_pkg::ST_S0);
  endtask : try_wake

  task automatic t_wake();
    try_wake(swpc_pkg::CODE_S1, 0, 1'b1);
    try_wake(swpc_pkg::CODE_S4, 0, 1'b0);
    try_wake(swpc_pkg::CODE_S4, 1, 1'b0);
    try_wake(swpc_pkg::CODE_S3, 2, 1'b0);
    try_wake(swpc_pkg::CODE_S5, 3, 1'b1);
    try_wake(swpc_pkg::CODE_S1, 3, 1'b1);
    try_wake(swpc_pkg::CODE_S4, 4, 1'b1);
    try_wake(swpc_pkg::CODE_S5, 4, 1'b0);
    wr(swpc_pkg::OFS_CTRL, 32'h3A);
    wr(swpc_pkg::OFS_WAKE_EN, 32'h7F7F3);
    try_wake(swpc_pkg::CODE_S4, 1, 1'b1);
    try_wake(swpc_pkg::CODE_S3, 2, 1'b1);
    try_wake(swpc_pkg::CODE_S5, 2, 1'b0);
    $display("t_wake done");
  endtask : t_wake

  // AC outages under each restore setting.
  task automatic t_ac();
    far.hold(6, 8);
    repeat (6) @(posedge ref_clk);
    expect_st(swpc_pkg::ST_S0);
    wr(swpc_pkg::OFS_CTRL, 32'h30);
    far.hold(6, 8);
    repeat (6) @(posedge ref_clk);
    expect_st(swpc_pkg::ST_S5);
    wr(swpc_pkg::OFS_CTRL, 32'h31);
    far.hold(6, 8);
    repeat (6) @(posedge ref_clk);
    expect_st(swpc_pkg::ST_S0);
    // Last-state restore from soft-off must come back off.
    wr(swpc_pkg::OFS_CTRL, 32'h32);
    wr(swpc_pkg::OFS_SLEEP_CMD, 32'hD);
    far.hold(6, 8);
    repeat (6) @(posedge ref_clk);
    expect_st(swpc_pkg::ST_S5);
    $display("t_ac done");
  endtask : t_ac

  // With the clock enable low a register write is not taken.
  task automatic t_freeze();
    logic [31:0] d;
    @(posedge ref_clk);
    clk_en <= 1'b0;
    wr(swpc_pkg::OFS_CTRL, 32'h30);
    @(posedge ref_clk);
    clk_en <= 1'b1;
    rd(swpc_pkg::OFS_CTRL, d);
    check("frozen ctrl", 32'h32, d);
    $display("t_freeze done");
  endtask : t_freeze

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : wrap_up

  // Main sequence after ten cycles of reset.
  initial begin
    repeat (10) @(posedge ref_clk);
    nrst <= 1'b1;
    t_regs();
    t_button();
    t_soft();
    t_s3();
    t_wake();
    t_ac();
    t_freeze();
    wrap_up();
  end

  // The whole run needs well under two thousand cycles.
  initial begin
    repeat (20000) @(posedge ref_clk);
    errors++;
    wrap_up();
  end
endmodule : tb_swpc_ctrl
